// ---- design/lmd_defines.svh ----
`ifndef LMD_DEFINES_SVH
`define LMD_DEFINES_SVH

// apb register byte offsets
`define LMD_REG_CTRL        12'h000
`define LMD_REG_STATUS      12'h004
`define LMD_REG_IOMISS      12'h008
`define LMD_REG_WAITCFG     12'h00C
`define LMD_CTRL_RUN_BIT    0
`define LMD_CTRL_DRAM_BIT   1
`define LMD_CTRL_RST        2'h3

// clock rates in hz
`define LMD_MASTER_HZ       14745600
`define LMD_DOUBLE_HZ       7372800
`define LMD_PROC_HZ         3686400
`define LMD_BASE_HZ         1843200
`define LMD_DIV_DOUBLE      (`LMD_MASTER_HZ / `LMD_DOUBLE_HZ)
`define LMD_DIV_PROC        (`LMD_MASTER_HZ / `LMD_PROC_HZ)
`define LMD_DIV_BASE        (`LMD_MASTER_HZ / `LMD_BASE_HZ)

// slow memory access time and its cycle count at the system clock
`define LMD_CLK_MHZ         20
`define LMD_SLOW_ACCESS_NS  250
`define LMD_SLOW_ACCESS_CYC ((`LMD_SLOW_ACCESS_NS * `LMD_CLK_MHZ + 999) / 1000)

// memory windows
`define LMD_LOWER_TOP_SMALL 16'h1FFF
`define LMD_LOWER_TOP_BIG   16'h3FFF
`define LMD_UPPER_BASE      16'h2000
`define LMD_UPPER_TOP       16'h3FFF
`define LMD_LOW16K_TOP      16'h3FFF
`define LMD_DRAM_BASE       16'h4000

// io windows
`define LMD_IO_SER_FIRST    8'h70
`define LMD_IO_SER_LAST     8'h7F
`define LMD_IO_CTR_FIRST    8'hD0
`define LMD_IO_CTR_LAST     8'hDB
`define LMD_IO_MIA_FIRST    8'hE0
`define LMD_IO_MIA_LAST     8'hEB
// bit 3 held low and bits 2..0 stop at 6, so the backplane array takes only seven ports
`define LMD_IO_BIA_HIGH     5'h16
`define LMD_IO_BIA_LAST     3'h6

// jumper positions, closed reads as 1
`define LMD_JP_A            0
`define LMD_JP_B            1
`define LMD_JP_C            2
`define LMD_JP_D            3
`define LMD_JP_E            4
`define LMD_JP_F            5
`define LMD_JP_G            6
`define LMD_JP_H            7
`define LMD_JP_J            8

`endif

// ---- design/lmd_pkg.sv ----
package lmd_pkg;

  typedef enum logic [1:0] {LOWER_NONE, LOWER_ROM4K, LOWER_ROM8K, LOWER_ROM16K} lmd_lower_t;

  typedef enum logic [2:0] {UPPER_NONE, UPPER_ROM4K, UPPER_ROM8K, UPPER_SRAM2K,
                            UPPER_SRAM8K} lmd_upper_t;

  typedef enum logic [1:0] {WAIT_IDLE, WAIT_HOLD, WAIT_DONE} lmd_wait_state_t;

endpackage : lmd_pkg

// ---- design/lmd_wait_if.sv ----
`timescale 1ns/100ps
interface lmd_wait_if;
  logic       start;
  logic       gate;
  logic [3:0] states;
  logic       access_end;
  logic       req;
  logic       wait_n;

  modport ctrl (output start, output gate, output states, output access_end,
                input req, input wait_n);
  modport gen  (input start, input gate, input states, input access_end,
                output req, output wait_n);
endinterface : lmd_wait_if

// ---- design/lmd_wait_gen.sv ----
`timescale 1ns/100ps
`include "lmd_defines.svh"
module lmd_wait_gen (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  lmd_wait_if.gen   wif
);
  lmd_pkg::lmd_wait_state_t state_r;
  logic [3:0]               cnt_r;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= lmd_pkg::WAIT_IDLE;
      cnt_r   <= 4'h0;
    end
    else
    begin
      case (state_r)
        lmd_pkg::WAIT_IDLE:
        begin
          if (wif.start)
          begin
            state_r <= lmd_pkg::WAIT_HOLD;
            cnt_r   <= wif.states;
          end
        end
        lmd_pkg::WAIT_HOLD:
        begin
          // released after the programmed count, never held forever
          if (cnt_r <= 4'h1)
            state_r <= lmd_pkg::WAIT_DONE;
          else
            cnt_r <= cnt_r - 4'h1;
        end
        lmd_pkg::WAIT_DONE:
        begin
          if (wif.access_end)
            state_r <= lmd_pkg::WAIT_IDLE;
        end
        default:
          state_r <= lmd_pkg::WAIT_IDLE;
      endcase
    end
  end

  assign wif.req    = (state_r == lmd_pkg::WAIT_HOLD); // R7
  assign wif.wait_n = !(wif.req && wif.gate); // R19
endmodule : lmd_wait_gen

// ---- design/lmd_top.sv ----
// What this block does
// R1: three locked clocks divided from master clock
// R2: slowest clock drives counter trigger inputs
// R3: middle clock is common processor system clock
// R4: lower socket window 3FFF if 16K, else 1FFF
// R5: upper socket window fixed 2000 to 3FFF
// R6: jumpers A-D lower, E-H upper, J gates wait
// R7: wait requested on every lowest 16K access
// R8: integrator closes J for parts over 250 ns
// R9: A,D closed, B,C open selects 16K lower
// R10: F,G open, H closed gives upper 4K ROM
// R11: E,H closed, F,G open gives upper 8K ROM
// R12: F,G closed, E,H open gives 2K SRAM
// R13: F,H closed, E,G open gives 8K SRAM
// R14: 64K dram mapped, 48K usable above sockets
// R15: dram refresh and row/column multiplex here
// R16: exactly 47 io ports decoded in four groups
// R17: firmware uses decoded io ports only
// R18: io select uses low eight address lines
// R19: active-low wait stretches access until released
// R20: B,C closed, A,D open gives 4K/8K lower ROM
// R21: other memory goes to dram, one source only; code sends only 4000 and up to dram, unused socket space below selects nothing
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "lmd_defines.svh"
module lmd_top #(
  parameter int REFRESH_CYCLES = 64
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic        cpu_mreq_n_i,
  input  wire logic        cpu_iorq_n_i,
  input  wire logic        cpu_rd_n_i,
  input  wire logic        cpu_wr_n_i,
  input  wire logic        cpu_m1_n_i,
  input  wire logic [8:0]  memory_config_jumper_i,
  output logic             double_rate_clock_o,
  output logic             processor_clock_o,
  output logic             counter_base_clock_o,
  output logic             double_rate_clock_en_o,
  output logic             processor_clock_en_o,
  output logic             counter_base_clock_en_o,
  output logic             counter_trigger_input_o,
  output logic             lower_rom_socket_sel_o,
  output logic             upper_memory_socket_sel_o,
  output logic             upper_memory_socket_we_o,
  output logic             dram_sel_o,
  output logic [7:0]       dram_mux_addr_o,
  output logic             dram_refresh_o,
  output logic             serial_channel_part_sel_o,
  output logic             counter_timer_part_sel_o,
  output logic             memory_interface_array_sel_o,
  output logic             backplane_interface_array_sel_o,
  output logic [3:0]       io_port_index_o,
  output logic             io_unmapped_o,
  output logic             mia_wait_req_o,
  output logic             cpu_wait_n_o,
  output logic             card_reset_n_o
);
  logic [2:0]  div_cnt_r;
  logic [1:0]  ctrl_r;
  logic [3:0]  wait_cfg_r;
  logic [15:0] io_miss_r;
  logic        mreq_prev_r;
  logic        io_prev_r;
  logic        col_phase_r;
  logic [7:0]  refresh_row_r;
  logic [7:0]  refresh_cnt_r;
  logic        mem_start;
  logic        io_cycle;
  logic        io_start;
  logic        apb_wr;
  logic        apb_rd;
  lmd_pkg::lmd_lower_t lower_cfg;
  lmd_pkg::lmd_upper_t upper_cfg;
  lmd_wait_if wif ();

  function automatic logic div_hit(input logic [2:0] cnt, input logic [2:0] mask);
    div_hit = ((cnt & mask) == mask);
  endfunction : div_hit

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic jp(input logic [8:0] j, input int pos);
    jp = j[pos];
  endfunction : jp

  // lower socket setting from positions A..D
  function automatic lmd_pkg::lmd_lower_t lower_decode(input logic [8:0] j);
    if (jp(j, `LMD_JP_A) && !jp(j, `LMD_JP_B) && !jp(j, `LMD_JP_C) && jp(j, `LMD_JP_D))
      lower_decode = lmd_pkg::LOWER_ROM16K; // R9
    else if (!jp(j, `LMD_JP_A) && jp(j, `LMD_JP_B) && !jp(j, `LMD_JP_D))
      // C closed reads as the smaller part; both decode the same window
      lower_decode = jp(j, `LMD_JP_C) ? lmd_pkg::LOWER_ROM4K : lmd_pkg::LOWER_ROM8K; // R20
    else
      lower_decode = lmd_pkg::LOWER_NONE;
  endfunction : lower_decode

  // upper socket setting from positions E..H
  function automatic lmd_pkg::lmd_upper_t upper_decode(input logic [8:0] j);
    if (!jp(j, `LMD_JP_F) && !jp(j, `LMD_JP_G) && jp(j, `LMD_JP_H))
      // E closed picks the 8K part, E open the 4K part
      upper_decode = jp(j, `LMD_JP_E) ? lmd_pkg::UPPER_ROM8K : lmd_pkg::UPPER_ROM4K; // R10 R11
    else if (!jp(j, `LMD_JP_E) && jp(j, `LMD_JP_F) && jp(j, `LMD_JP_G) && !jp(j, `LMD_JP_H))
      upper_decode = lmd_pkg::UPPER_SRAM2K; // R12
    else if (!jp(j, `LMD_JP_E) && jp(j, `LMD_JP_F) && !jp(j, `LMD_JP_G) && jp(j, `LMD_JP_H))
      upper_decode = lmd_pkg::UPPER_SRAM8K; // R13
    else
      upper_decode = lmd_pkg::UPPER_NONE;
  endfunction : upper_decode

  // clock divider, all three rates from one counter so edges stay aligned
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      div_cnt_r <= 3'h0;
    else if (ctrl_r[`LMD_CTRL_RUN_BIT])
      div_cnt_r <= div_cnt_r + 3'h1; // R1
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      double_rate_clock_o  <= 1'b0;
      processor_clock_o    <= 1'b0;
      counter_base_clock_o <= 1'b0;
    end
    else
    begin
      double_rate_clock_o  <= div_cnt_r[0]; // R1
      processor_clock_o    <= div_cnt_r[1]; // R3
      counter_base_clock_o <= div_cnt_r[2]; // R2
    end
  end

  assign double_rate_clock_en_o  = ctrl_r[`LMD_CTRL_RUN_BIT] &&
                                   div_hit(div_cnt_r, 3'(`LMD_DIV_DOUBLE - 1)); // R1
  assign processor_clock_en_o    = ctrl_r[`LMD_CTRL_RUN_BIT] &&
                                   div_hit(div_cnt_r, 3'(`LMD_DIV_PROC - 1)); // R3
  assign counter_base_clock_en_o = ctrl_r[`LMD_CTRL_RUN_BIT] &&
                                   div_hit(div_cnt_r, 3'(`LMD_DIV_BASE - 1)); // R2
  assign counter_trigger_input_o = counter_base_clock_o; // R2

  assign lower_cfg = lower_decode(memory_config_jumper_i); // R6
  assign upper_cfg = upper_decode(memory_config_jumper_i); // R6

  // memory decode, registered so selects are glitch free
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      lower_rom_socket_sel_o    <= 1'b0;
      upper_memory_socket_sel_o <= 1'b0;
      upper_memory_socket_we_o  <= 1'b0;
      dram_sel_o                <= 1'b0;
    end
    else
    begin
      lower_rom_socket_sel_o    <= 1'b0;
      upper_memory_socket_sel_o <= 1'b0;
      upper_memory_socket_we_o  <= 1'b0;
      dram_sel_o                <= 1'b0;
      if (!cpu_mreq_n_i)
      begin
        if (lower_cfg == lmd_pkg::LOWER_ROM16K)
        begin
          // upper socket is empty in this mode; never drive both
          lower_rom_socket_sel_o <= in_range(cpu_addr_i, 16'h0000,
                                             `LMD_LOWER_TOP_BIG); // R4 R9 R21
        end
        else
        begin
          lower_rom_socket_sel_o <= (lower_cfg != lmd_pkg::LOWER_NONE) &&
                                    in_range(cpu_addr_i, 16'h0000,
                                             `LMD_LOWER_TOP_SMALL); // R4 R20
          upper_memory_socket_sel_o <= (upper_cfg != lmd_pkg::UPPER_NONE) &&
                                       in_range(cpu_addr_i, `LMD_UPPER_BASE,
                                                `LMD_UPPER_TOP); // R5
          upper_memory_socket_we_o  <= !cpu_wr_n_i &&
                                       ((upper_cfg == lmd_pkg::UPPER_SRAM2K) ||
                                        (upper_cfg == lmd_pkg::UPPER_SRAM8K)) &&
                                       in_range(cpu_addr_i, `LMD_UPPER_BASE,
                                                `LMD_UPPER_TOP); // R12 R13
        end
        dram_sel_o <= ctrl_r[`LMD_CTRL_DRAM_BIT] &&
                      (cpu_addr_i >= `LMD_DRAM_BASE); // R14 R21
      end
    end
  end

  // dram row first, column from the first double-rate tick of the access, refresh when idle
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      col_phase_r <= 1'b0;
    else if (cpu_mreq_n_i)
      col_phase_r <= 1'b0;
    else if (double_rate_clock_en_o)
      col_phase_r <= 1'b1; // R15
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      refresh_cnt_r  <= 8'h00;
      refresh_row_r  <= 8'h00;
      dram_refresh_o <= 1'b0;
    end
    else
    begin
      dram_refresh_o <= 1'b0;
      if (processor_clock_en_o)
      begin
        if (refresh_cnt_r >= 8'(REFRESH_CYCLES - 1))
        begin
          refresh_cnt_r <= 8'h00;
          // refresh skipped for this period while the processor holds memory
          if (cpu_mreq_n_i)
          begin
            dram_refresh_o <= 1'b1; // R15
            refresh_row_r  <= refresh_row_r + 8'h01;
          end
        end
        else
          refresh_cnt_r <= refresh_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      dram_mux_addr_o <= 8'h00;
    else if (cpu_mreq_n_i)
      dram_mux_addr_o <= refresh_row_r; // R15
    else if (col_phase_r)
      dram_mux_addr_o <= cpu_addr_i[7:0]; // R15
    else
      dram_mux_addr_o <= cpu_addr_i[15:8]; // R15
  end

  // io decode; interrupt acknowledge (m1 with iorq) is not a port access
  assign io_cycle = !cpu_iorq_n_i && cpu_m1_n_i;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      serial_channel_part_sel_o       <= 1'b0;
      counter_timer_part_sel_o        <= 1'b0;
      memory_interface_array_sel_o    <= 1'b0;
      backplane_interface_array_sel_o <= 1'b0;
      io_port_index_o                 <= 4'h0;
      io_unmapped_o                   <= 1'b0;
    end
    else
    begin
      serial_channel_part_sel_o       <= 1'b0;
      counter_timer_part_sel_o        <= 1'b0;
      memory_interface_array_sel_o    <= 1'b0;
      backplane_interface_array_sel_o <= 1'b0;
      io_unmapped_o                   <= 1'b0;
      io_port_index_o                 <= cpu_addr_i[3:0]; // R18
      if (io_cycle)
      begin
        if (cpu_addr_i[7:0] >= `LMD_IO_SER_FIRST && cpu_addr_i[7:0] <= `LMD_IO_SER_LAST)
          serial_channel_part_sel_o <= 1'b1; // R16
        else if (cpu_addr_i[7:0] >= `LMD_IO_CTR_FIRST &&
                 cpu_addr_i[7:0] <= `LMD_IO_CTR_LAST)
          counter_timer_part_sel_o <= 1'b1; // R16
        else if (cpu_addr_i[7:0] >= `LMD_IO_MIA_FIRST &&
                 cpu_addr_i[7:0] <= `LMD_IO_MIA_LAST)
          memory_interface_array_sel_o <= 1'b1; // R16
        else if (cpu_addr_i[7:3] == `LMD_IO_BIA_HIGH &&
                 cpu_addr_i[2:0] <= `LMD_IO_BIA_LAST)
          backplane_interface_array_sel_o <= 1'b1; // R16
        else
          io_unmapped_o <= 1'b1; // R17
      end
    end
  end

  // access edge detection for wait and miss counting
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mreq_prev_r <= 1'b1;
      io_prev_r   <= 1'b0;
    end
    else
    begin
      mreq_prev_r <= cpu_mreq_n_i;
      io_prev_r   <= io_cycle;
    end
  end

  assign mem_start = !cpu_mreq_n_i && mreq_prev_r &&
                     (cpu_addr_i <= `LMD_LOW16K_TOP); // R7
  assign io_start  = io_cycle && !io_prev_r;

  assign wif.start      = mem_start; // R7
  assign wif.gate       = memory_config_jumper_i[`LMD_JP_J]; // R6 R8
  assign wif.states     = wait_cfg_r;
  assign wif.access_end = cpu_mreq_n_i; // R19

  lmd_wait_gen u_wait (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .wif       (wif.gen)
  );

  assign mia_wait_req_o = wif.req; // R7
  assign cpu_wait_n_o   = wif.wait_n; // R19

  // card reset released one clock after the block's own reset
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      card_reset_n_o <= 1'b0;
    else
      card_reset_n_o <= 1'b1; // R15
  end

  // apb slave, zero wait states
  assign apb_wr    = psel_i && penable_i && pwrite_i;
  assign apb_rd    = psel_i && !pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i &&
                     !((paddr_i == `LMD_REG_CTRL) || (paddr_i == `LMD_REG_STATUS) ||
                       (paddr_i == `LMD_REG_IOMISS) || (paddr_i == `LMD_REG_WAITCFG));

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ctrl_r <= `LMD_CTRL_RST;
    else if (apb_wr && paddr_i == `LMD_REG_CTRL)
      ctrl_r <= pwdata_i[1:0];
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      wait_cfg_r <= 4'(`LMD_SLOW_ACCESS_CYC);
    else if (apb_wr && paddr_i == `LMD_REG_WAITCFG)
      wait_cfg_r <= (pwdata_i[3:0] == 4'h0) ? 4'h1 : pwdata_i[3:0];
  end

  // miss counter: a new miss and a software clear in the same cycle leave a count of one
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      io_miss_r <= 16'h0000;
    else if (io_start && !io_unmapped_hit(cpu_addr_i[7:0]))
      io_miss_r <= (apb_wr && paddr_i == `LMD_REG_IOMISS) ? 16'h0001 :
                   ((io_miss_r == 16'hFFFF) ? io_miss_r : io_miss_r + 16'h0001); // R17
    else if (apb_wr && paddr_i == `LMD_REG_IOMISS)
      io_miss_r <= 16'h0000;
  end

  function automatic logic io_unmapped_hit(input logic [7:0] a);
    io_unmapped_hit = (a >= `LMD_IO_SER_FIRST && a <= `LMD_IO_SER_LAST) ||
                      (a >= `LMD_IO_CTR_FIRST && a <= `LMD_IO_CTR_LAST) ||
                      (a >= `LMD_IO_MIA_FIRST && a <= `LMD_IO_MIA_LAST) ||
                      (a[7:3] == `LMD_IO_BIA_HIGH && a[2:0] <= `LMD_IO_BIA_LAST);
  endfunction : io_unmapped_hit

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      prdata_o <= 32'h0000_0000;
    else if (apb_rd && !penable_i)
    begin
      if (paddr_i == `LMD_REG_CTRL)
        prdata_o <= {30'h0, ctrl_r};
      else if (paddr_i == `LMD_REG_STATUS)
        prdata_o <= {16'h0, 1'b0, wif.req, memory_config_jumper_i, upper_cfg, lower_cfg};
      else if (paddr_i == `LMD_REG_IOMISS)
        prdata_o <= {16'h0, io_miss_r};
      else if (paddr_i == `LMD_REG_WAITCFG)
        prdata_o <= {28'h0, wait_cfg_r};
      else
        prdata_o <= 32'h0000_0000;
    end
  end
endmodule : lmd_top

// ---- tb/lmd_top_asserts.sv ----
`timescale 1ns/100ps
module lmd_top_asserts (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic        cpu_mreq_n_i,
  input  wire logic        cpu_iorq_n_i,
  input  wire logic        cpu_m1_n_i,
  input  wire logic [8:0]  memory_config_jumper_i,
  input  wire logic        double_rate_clock_o,
  input  wire logic        processor_clock_o,
  input  wire logic        counter_base_clock_o,
  input  wire logic        lower_rom_socket_sel_o,
  input  wire logic        upper_memory_socket_sel_o,
  input  wire logic        dram_sel_o,
  input  wire logic        serial_channel_part_sel_o,
  input  wire logic [3:0]  io_port_index_o,
  input  wire logic        mia_wait_req_o,
  input  wire logic        cpu_wait_n_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_low_start;
    $fell(cpu_mreq_n_i) && cpu_addr_i <= 16'h3FFF;
  endsequence
  sequence s_proc_rest;
    processor_clock_o ##1 !processor_clock_o [*2] ##1 processor_clock_o;
  endsequence
  clk_phase_a: assert property (
    $rose(counter_base_clock_o) |-> !processor_clock_o && !double_rate_clock_o)
    else $error("divided clocks out of step");
  double_toggle_a: assert property (
    $rose(double_rate_clock_o) |=> $fell(double_rate_clock_o))
    else $error("double rate clock not two cycles");
  proc_period_a: assert property ($rose(processor_clock_o) |=> s_proc_rest)
    else $error("processor clock not four cycles");
  wait_start_a: assert property (s_low_start |=> mia_wait_req_o)
    else $error("no wait on low region access");
  wait_gate_a: assert property (
    cpu_wait_n_o == !(mia_wait_req_o && memory_config_jumper_i[8]))
    else $error("wait not gated by jumper");
  one_source_a: assert property (
    $onehot0({lower_rom_socket_sel_o, upper_memory_socket_sel_o, dram_sel_o}))
    else $error("two memory sources selected");
  dram_steer_a: assert property (
    !cpu_mreq_n_i && cpu_addr_i >= 16'h4000 |=> dram_sel_o && !lower_rom_socket_sel_o)
    else $error("high access not steered to dram");
  io_index_a: assert property (
    !cpu_iorq_n_i && cpu_m1_n_i |=> io_port_index_o == $past(cpu_addr_i[3:0]))
    else $error("io index not from low lines");
  io_serial_a: assert property (
    !cpu_iorq_n_i && cpu_m1_n_i && cpu_addr_i[7:4] == 4'h7 |=> serial_channel_part_sel_o)
    else $error("serial port not selected");
endmodule : lmd_top_asserts

// ---- tb/lmd_cpu_model.sv ----
`timescale 1ns/100ps
module lmd_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        wait_n_i,
  output logic      [15:0] addr_o,
  output logic             mreq_n_o,
  output logic             iorq_n_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic             m1_n_o
);
  initial
  begin
    addr_o = 16'hFFFF;
    mreq_n_o = 1'b1;
    iorq_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    m1_n_o = 1'b1;
  end
  // idle gap first so every access counts as a fresh start
  task automatic cycle(input logic [15:0] a, input logic io, input logic wr, output int n);
    n = 0;
    repeat (3) @(posedge clk_i);
    addr_o   <= a;
    mreq_n_o <= io;
    iorq_n_o <= !io;
    rd_n_o   <= wr;
    wr_n_o   <= !wr;
    @(posedge clk_i);
    #1;
    // stretch while wait is low; bound stops a stuck design
    while (wait_n_i !== 1'b1 && n < 64)
    begin
      n++;
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    mreq_n_o <= 1'b1;
    iorq_n_o <= 1'b1;
    rd_n_o   <= 1'b1;
    wr_n_o   <= 1'b1;
    addr_o   <= ~a;
  endtask : cycle
endmodule : lmd_cpu_model

// ---- tb/tb_lmd_top.sv ----
`timescale 1ns/100ps
module tb_lmd_top;
  logic        clk;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [8:0]  jumper = 9'h000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] addr;
  logic        mreq_n;
  logic        iorq_n;
  logic        rd_n;
  logic        wr_n;
  logic        m1_n;
  logic        wait_n;
  logic        we;
  logic        crst;
  logic [2:0]  msel;
  logic [4:0]  iosel;
  logic [3:0]  idx;
  logic [2:0]  cen;
  logic [31:0] q;
  logic        e;
  int          n;
  int          hits = 0;
  int          c2 = 0;
  int          c4 = 0;
  int          c8 = 0;
  int          n_errors = 0;
  int          total_checks = 0;
  logic [8:0]  jp_tab [5] = '{9'h009, 9'h086, 9'h092, 9'h066, 9'h0A6};
  logic [15:0] ad_tab [5] = '{16'h3000, 16'h2100, 16'h1F00, 16'h2000, 16'h3F00};
  logic [4:0]  cf_tab [5] = '{5'h03, 5'h05, 5'h0A, 5'h0D, 5'h11};
  logic [2:0]  sl_tab [5] = '{3'h4, 3'h2, 3'h4, 3'h2, 3'h2};

  lmd_top #(.REFRESH_CYCLES(4)) u_lmd_top (
    .sys_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .cpu_addr_i(addr), .cpu_mreq_n_i(mreq_n),
    .cpu_iorq_n_i(iorq_n), .cpu_rd_n_i(rd_n), .cpu_wr_n_i(wr_n), .cpu_m1_n_i(m1_n),
    .memory_config_jumper_i(jumper), .double_rate_clock_o(), .processor_clock_o(),
    .counter_base_clock_o(), .double_rate_clock_en_o(cen[2]),
    .processor_clock_en_o(cen[1]), .counter_base_clock_en_o(cen[0]),
    .counter_trigger_input_o(), .lower_rom_socket_sel_o(msel[2]),
    .upper_memory_socket_sel_o(msel[1]), .upper_memory_socket_we_o(we),
    .dram_sel_o(msel[0]), .dram_mux_addr_o(), .dram_refresh_o(),
    .serial_channel_part_sel_o(iosel[4]), .counter_timer_part_sel_o(iosel[3]),
    .memory_interface_array_sel_o(iosel[2]), .backplane_interface_array_sel_o(iosel[1]),
    .io_port_index_o(idx), .io_unmapped_o(iosel[0]), .mia_wait_req_o(),
    .cpu_wait_n_o(wait_n), .card_reset_n_o(crst));

  lmd_cpu_model u_lmd_cpu_model (.clk_i(clk), .wait_n_i(wait_n), .addr_o(addr),
    .mreq_n_o(mreq_n), .iorq_n_o(iorq_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .m1_n_o(m1_n));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic timeout(input string nm);
    chk(nm, 32'h1, 32'h0);
    finish_test();
  endtask : timeout

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 50 && pready !== 1'b1; k++) @(posedge clk);
    if (k == 50)
      timeout("apb_ready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cpu(input logic [15:0] a, input logic io, input logic wr);
    u_lmd_cpu_model.cycle(a, io, wr, n);
    if (n >= 64)
      timeout("cpu_wait");
    #1;
  endtask : cpu

  // jumpers may pass a synchroniser, so let them settle
  task automatic set_jp(input logic [8:0] j);
    @(posedge clk);
    jumper <= j;
    repeat (3) @(posedge clk);
  endtask : set_jp

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, q, e);
    chk("ctrl_reset", 32'h3, q);
    apb(1'b0, 12'h00C, 32'h0, q, e);
    chk("waitcfg_reset", 32'h5, q);
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("card_reset", 32'h1, {31'h0, crst});
    for (int i = 0; i < 5; i++)
    begin
      set_jp(jp_tab[i]);
      apb(1'b0, 12'h004, 32'h0, q, e);
      chk("status_cfg", {18'h0, jp_tab[i], cf_tab[i]}, q);
      cpu(ad_tab[i], 1'b0, i == 3);
      chk("mem_select", {29'h0, sl_tab[i]}, {29'h0, msel});
      chk("wait_gated", 32'h0, n);
      chk("sram_we", {31'h0, i == 3}, {31'h0, we});
    end
    set_jp(9'h109);
    cpu(16'h3FFF, 1'b0, 1'b0);
    chk("wait_cycles", 32'h5, n);
    apb(1'b1, 12'h00C, 32'h0, q, e);
    apb(1'b0, 12'h00C, 32'h0, q, e);
    chk("waitcfg_min", 32'h1, q);
    apb(1'b1, 12'h00C, 32'h2, q, e);
    cpu(16'h0000, 1'b0, 1'b1);
    chk("wait_cycles", 32'h2, n);
    cpu(16'h4000, 1'b0, 1'b0);
    chk("dram_nowait", 32'h0, n);
    chk("dram_select", 32'h1, {29'h0, msel});
    // full port sweep, high byte set to show it is ignored
    for (int i = 0; i < 256; i++)
    begin
      cpu({8'hA5, i[7:0]}, 1'b1, 1'b0);
      hits += (iosel[4:1] != 4'h0);
      chk("io_onehot", 32'h1, {31'h0, $onehot(iosel)});
      chk("io_index", {28'h0, i[3:0]}, {28'h0, idx});
    end
    chk("io_decoded", 32'h2F, hits);
    apb(1'b0, 12'h008, 32'h0, q, e);
    chk("io_misses", 32'hD1, q);
    repeat (40)
    begin
      @(posedge clk);
      #1;
      c2 += cen[2];
      c4 += cen[1];
      c8 += cen[0];
    end
    chk("double_en", 32'h14, c2);
    chk("proc_en", 32'hA, c4);
    chk("base_en", 32'h5, c8);
    finish_test();
  end
endmodule : tb_lmd_top

bind lmd_top lmd_top_asserts u_lmd_top_asserts (.sys_clk_i, .reset_n_i, .cpu_addr_i,
  .cpu_mreq_n_i, .cpu_iorq_n_i, .cpu_m1_n_i, .memory_config_jumper_i, .double_rate_clock_o,
  .processor_clock_o, .counter_base_clock_o, .lower_rom_socket_sel_o,
  .upper_memory_socket_sel_o, .dram_sel_o, .serial_channel_part_sel_o, .io_port_index_o,
  .mia_wait_req_o, .cpu_wait_n_o);
